/* late_write_sram_pkg.sv */
// package: widths, geometry and carrier types of the late-write parity sram core
package late_write_sram_pkg;
  localparam int unsigned ADDR_W    = 19;                   // word address, x36 organisation
  localparam int unsigned LANES     = 4;                    // byte lanes per word
  localparam int unsigned LANE_W    = 9;                    // eight data bits plus parity
  localparam int unsigned DATA_W    = LANES * LANE_W;       // 36-bit word
  localparam int unsigned DEPTH     = 524288;               // words in full-capacity mode
  localparam int unsigned BANK_BIT  = ADDR_W - 1;           // extra address pin, ignored in dual-bank mode; set internally for the secondary bank
  localparam int unsigned RST_SYNC  = 2;                    // reset release stages
  localparam int unsigned PIN_SYNC  = 2;                    // stages for asynchronous strap and sleep pins

  // one accepted write, between address edge and data edge
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;                               // high = lane written
  } wr_cmd_t;

  // one-deep write buffer entry
  typedef struct packed {
    logic              valid;
    logic              ec;                                  // written while dual-bank mode was active
    logic [ADDR_W-1:0] addr;                                // effective (primary) address
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] data;
  } wr_buf_t;
endpackage : late_write_sram_pkg

/* late_write_sram_dual_bank_parity.sv */
// design: synchronous sram core with late write, one-deep write buffer and dual-bank parity mode
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] strap high full array, low half ignores top
// [R2] 524,288 words of 36 bits, four lanes
// [R3] dual-bank writes commit to both banks via buffer
// [R4] odd-parity primary byte goes to outputs
// [R5] even-parity primary byte replaced by secondary byte
// [R6] bank choice made per byte lane
// [R7] secondary bytes pass without parity check
// [R8] one pending write buffered, bypassing parity check
// [R9] controls sampled on rising edge, sleep asynchronous
// [R10] read data driven from following falling edge
// [R11] write data captured one cycle after address
// [R12] host ties read-protocol strap high
// [R13] host ties output enable low
// [R14] select, write, byte enables decode operation
// [R15] host brackets strap change with deselects
// [R16] sleep forces outputs off, keeps array
// [R17] read hitting buffer returns buffered enabled lanes
// [R18] nine-bit lanes, parity over all nine
// [R19] outputs off after deselect and write
module late_write_sram_dual_bank_parity (
  // clock, enable, reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     ce,
  input  wire logic                                     resetn,
  // straps and sleep (asynchronous)
  input  wire logic                                     ec_mode_select,
  input  wire logic                                     read_protocol_select,
  input  wire logic                                     output_enable_n,
  input  wire logic                                     sleep_request,
  // synchronous command inputs
  input  wire logic                                     select_n,
  input  wire logic                                     write_enable_n,
  input  wire logic [late_write_sram_pkg::LANES-1:0]    byte_write_enable_n,
  input  wire logic [late_write_sram_pkg::ADDR_W-1:0]   sync_address_in,
  // data pins split into in, out, enable
  input  wire logic [late_write_sram_pkg::DATA_W-1:0]   dq_in,
  output logic      [late_write_sram_pkg::DATA_W-1:0]   dq_out,
  output logic                                          dq_oe,
  // mode status
  output logic                                          dual_bank_parity_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [late_write_sram_pkg::RST_SYNC-1:0] rst_sync_reg;   // reset release chain
  logic [late_write_sram_pkg::PIN_SYNC-1:0] sleep_sync_reg; // sleep into clock domain
  logic [late_write_sram_pkg::PIN_SYNC-1:0] mode_sync_reg;  // mode strap into clock domain
  logic                                     rst_n;          // synchronised reset
  logic                                     sleep_s;        // synchronised sleep
  logic                                     late_write_mode;// always on; r-l protocol is strapped by host

  assign rst_n           = rst_sync_reg[late_write_sram_pkg::RST_SYNC-1];
  assign sleep_s         = sleep_sync_reg[late_write_sram_pkg::PIN_SYNC-1];
  assign late_write_mode = 1'b1;

  // reset: asserted at once, released after two edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[late_write_sram_pkg::RST_SYNC-2:0], 1'b1};
    end
  end

  // sleep and strap go through two stages; only the output-enable gate reads the raw sleep pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sync_reg <= '0;
      mode_sync_reg  <= '1;
    end else if (ce) begin
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_request};
      mode_sync_reg  <= {mode_sync_reg[0], ec_mode_select};
    end
  end

  // low strap selects the half-capacity dual-bank mode
  assign dual_bank_parity_mode = ~mode_sync_reg[late_write_sram_pkg::PIN_SYNC-1]; // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // address helpers

  // primary address: in dual-bank mode the extra pin is ignored
  function automatic logic [late_write_sram_pkg::ADDR_W-1:0] prim_addr(
    input logic [late_write_sram_pkg::ADDR_W-1:0] a,
    input logic                                   ec
  );
    prim_addr = a;
    if (ec) begin
      prim_addr[late_write_sram_pkg::BANK_BIT] = 1'b0; // [R1]
    end
  endfunction : prim_addr

  // secondary bank copy lives in the upper half
  function automatic logic [late_write_sram_pkg::ADDR_W-1:0] sec_addr(
    input logic [late_write_sram_pkg::ADDR_W-1:0] a
  );
    sec_addr = a;
    sec_addr[late_write_sram_pkg::BANK_BIT] = 1'b1;
  endfunction : sec_addr

  ////////////////////////////////////////////////////////////////////////////
  // command stage: taken on the rising edge
  logic                              rd_pend_reg;    // read address registered last edge
  logic [late_write_sram_pkg::ADDR_W-1:0] rd_addr_reg;    // its address
  logic                              wr_pend_reg;    // write address registered, data due next edge
  late_write_sram_pkg::wr_cmd_t      wr_cmd_reg;     // its address and lanes
  logic                              op_read;        // decoded read
  logic                              op_write;       // decoded write with at least one lane

  assign op_read  = !sleep_s && !select_n && write_enable_n;                          // [R14]
  assign op_write = !sleep_s && !select_n && !write_enable_n
                    && late_write_mode && !(&byte_write_enable_n);                    // [R14]

  // deselect, abort and sleep leave both pending flags low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      wr_pend_reg <= 1'b0;
      wr_cmd_reg  <= '0;
    end else if (ce) begin
      rd_pend_reg <= op_read;                        // [R9]
      wr_pend_reg <= op_write;                       // [R9]
      if (op_read) begin
        rd_addr_reg <= sync_address_in;
      end
      if (op_write) begin
        wr_cmd_reg.addr  <= prim_addr(sync_address_in, dual_bank_parity_mode);
        wr_cmd_reg.lanes <= ~byte_write_enable_n;    // low enable writes the lane
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write buffer and array
  late_write_sram_pkg::wr_buf_t      buf_reg;        // one pending write
  // flip-flop array, full-capacity depth of four-lane words
  logic [late_write_sram_pkg::DATA_W-1:0] mem [late_write_sram_pkg::DEPTH]; // [R2]

  // data arrives one edge after its address; the older entry is then committed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_reg <= '0;
    end else if (ce && wr_pend_reg) begin
      buf_reg.valid <= 1'b1;                         // [R8]
      buf_reg.ec    <= dual_bank_parity_mode;
      buf_reg.addr  <= wr_cmd_reg.addr;
      buf_reg.lanes <= wr_cmd_reg.lanes;
      buf_reg.data  <= dq_in;                        // [R11]
    end
  end

  // array has no reset; contents survive sleep and mode changes
  always_ff @(posedge clk_sys) begin
    if (ce && wr_pend_reg && buf_reg.valid) begin
      for (int i = 0; i < late_write_sram_pkg::LANES; i++) begin
        if (buf_reg.lanes[i]) begin
          mem[buf_reg.addr][i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W] <=
            buf_reg.data[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W];
          if (buf_reg.ec) begin
            mem[sec_addr(buf_reg.addr)][i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W] <=
              buf_reg.data[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W]; // [R3]
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word assembly, per lane
  logic [late_write_sram_pkg::DATA_W-1:0] prim_word;  // primary (or plain) word
  logic [late_write_sram_pkg::DATA_W-1:0] sec_word;   // secondary bank word
  logic [late_write_sram_pkg::DATA_W-1:0] rd_word;    // word to be driven
  logic                                   buf_hit;    // read address held in buffer

  assign prim_word = mem[prim_addr(rd_addr_reg, dual_bank_parity_mode)];
  assign sec_word  = mem[sec_addr(rd_addr_reg)];
  assign buf_hit   = buf_reg.valid && (buf_reg.addr == prim_addr(rd_addr_reg, dual_bank_parity_mode)); // [R17]

  // buffer beats array; in dual-bank mode bad primary parity falls back to secondary
  always_comb begin
    logic [late_write_sram_pkg::LANE_W-1:0] p_lane;
    p_lane  = '0;
    rd_word = prim_word;
    for (int i = 0; i < late_write_sram_pkg::LANES; i++) begin
      p_lane = prim_word[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W];
      if (buf_hit && buf_reg.lanes[i]) begin
        // buffered bytes go out unchecked
        rd_word[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W] =
          buf_reg.data[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W]; // [R8] [R17]
      end else if (dual_bank_parity_mode && !(^p_lane)) begin
        // even parity over all nine bits: take secondary lane as is
        rd_word[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W] =
          sec_word[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W]; // [R5] [R6] [R7] [R18]
      end else begin
        rd_word[i*late_write_sram_pkg::LANE_W +: late_write_sram_pkg::LANE_W] = p_lane; // [R4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latch on the falling edge
  logic [late_write_sram_pkg::DATA_W-1:0] dq_out_reg; // latched read word
  logic                                   dq_oe_reg;  // drive for this cycle

  // only a read drives; writes and deselects leave the pins off
  always_ff @(negedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_out_reg <= '0;
      dq_oe_reg  <= 1'b0;
    end else if (ce) begin
      dq_oe_reg <= rd_pend_reg;                      // [R10] [R19]
      if (rd_pend_reg) begin
        dq_out_reg <= rd_word;                       // [R10]
      end
    end
  end

  // sleep cuts the drivers at once, without waiting for a clock
  assign dq_out = dq_out_reg;
  assign dq_oe  = dq_oe_reg && !sleep_request;       // [R16]

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_read_drives: assert property (ce |-> (dq_oe_reg == rd_pend_reg)) // [R10]
    else $error("output enable does not follow the registered read");
  a_write_hiz: assert property ((ce && wr_pend_reg) |-> !dq_oe) // [R19]
    else $error("outputs driven during write address cycle");
  a_sleep_hiz: assert property (sleep_request |-> !dq_oe) // [R16]
    else $error("outputs driven while sleep is requested");
  a_abort_write: assert property ((ce && !sleep_s && !select_n && !write_enable_n
                                   && (&byte_write_enable_n)) |=> !wr_pend_reg) // [R14]
    else $error("aborted write was accepted");
  a_deselect_idle: assert property ((ce && select_n) |=> (!rd_pend_reg && !wr_pend_reg)) // [R14]
    else $error("deselect started an operation");
  a_late_data: assert property ((ce && op_write) ##1 ce |=>
                                (buf_reg.valid && buf_reg.data == $past(dq_in))) // [R11]
    else $error("write data not captured one cycle after address");
  a_dual_copy: assert property ((ce && wr_pend_reg && buf_reg.valid && buf_reg.ec && buf_reg.lanes[0])
                                |=> (mem[$past(buf_reg.addr)][8:0] == mem[sec_addr($past(buf_reg.addr))][8:0])) // [R3]
    else $error("dual-bank write left banks different");
  a_bad_parity: assert property ((rd_pend_reg && dual_bank_parity_mode && !(buf_hit && buf_reg.lanes[0])
                                  && !(^prim_word[8:0])) |-> (rd_word[8:0] == sec_word[8:0])) // [R5]
    else $error("even parity lane not replaced");
  a_good_parity: assert property ((rd_pend_reg && dual_bank_parity_mode && !(buf_hit && buf_reg.lanes[1])
                                   && (^prim_word[17:9])) |-> (rd_word[17:9] == prim_word[17:9])) // [R4]
    else $error("odd parity lane not driven from primary");
  a_plain_read: assert property ((rd_pend_reg && !dual_bank_parity_mode && !buf_hit)
                                 |-> (rd_word == mem[rd_addr_reg])) // [R1]
    else $error("full-capacity read returned wrong word");

  c_sub_read:   cover property (rd_pend_reg && dual_bank_parity_mode && (rd_word != prim_word));
  c_buf_hit:    cover property (rd_pend_reg && buf_hit);
  c_abort:      cover property (!select_n && !write_enable_n && (&byte_write_enable_n) && !sleep_s);
  c_sleep:      cover property (sleep_s);

endmodule : late_write_sram_dual_bank_parity
`default_nettype wire

/* host_model.sv */
// host memory controller model that drives the sram command and data pins
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input  wire logic        clk_sys,
  // read side seen from the pins
  input  wire logic [35:0] dq_out,
  input  wire logic        dq_oe,
  // command and strap pins
  output logic             select_n,
  output logic             write_enable_n,
  output logic [3:0]       byte_write_enable_n,
  output logic [18:0]      sync_address_in,
  output logic [35:0]      dq_in,
  output logic             ec_mode_select,
  output logic             sleep_request,
  output logic             read_protocol_select,
  output logic             output_enable_n
);
  // fixed straps
  assign read_protocol_select = 1'b1;
  assign output_enable_n      = 1'b0;
  // idle bus at time zero
  initial begin
    {select_n, write_enable_n, byte_write_enable_n} = 6'h3F;
    sync_address_in = '0;
    dq_in = '0;
    ec_mode_select = 1'b1;
    sleep_request = 1'b0;
  end
  // n deselects, pins move 2 ns after the edge
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #2;
      select_n = 1'b1;
    end
  endtask : idle
  // late write: address edge, then data on the next edge
  task automatic wr(input logic [18:0] a, input logic [3:0] ben_n, input logic [35:0] d);
    idle(1);
    {select_n, write_enable_n, byte_write_enable_n, sync_address_in} = {2'b00, ben_n, a};
    idle(1);
    write_enable_n = 1'b1;
    dq_in = d;
    idle(1);
    dq_in = ~d; // released lines must not keep the old word
  endtask : wr
  // read: sample data and enable mid low phase, then oe in the deselect after
  task automatic rd(input logic [18:0] a, output logic [35:0] q, output logic oe, output logic oe2);
    idle(1);
    {select_n, write_enable_n, sync_address_in} = {2'b01, a};
    idle(1);
    #11;
    q = dq_out;
    oe = dq_oe;
    #20;
    oe2 = dq_oe;
  endtask : rd
  // strap change bracketed by deselects
  task automatic strap(input logic full);
    idle(2);
    ec_mode_select = full;
    idle(32);
  endtask : strap
  // sleep pin moves 2 ns after an edge, like every other pin
  task automatic sleep_set(input logic v);
    @(posedge clk_sys);
    #2;
    sleep_request = v;
  endtask : sleep_set
endmodule : host_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the late-write parity sram core
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys, resetn;
  wire logic sel_n, we_n, rps, oe_n, slp, ecm, dq_oe, dbm;
  wire logic [3:0] ben_n;
  wire logic [18:0] addr;
  wire logic [35:0] dq_in, dq_out;
  int n_fail = 0, n_checks = 0;
  logic [35:0] q;
  logic oe, oe2;
  // words and addresses; top address bit picks the secondary half
  localparam logic [18:0] A = 19'h00010, C = 19'h00030, D = 19'h00040, TOP = 19'h40000;
  localparam logic [35:0] W1 = 36'h123456789, W2 = 36'hFEDCBA987, MSK = 36'hFF803FE00;
  localparam logic [35:0] P = {9'h001, 9'h003, 9'h007, 9'h000}, S = {4{9'h0F0}}, E = {4{9'h003}};
  host_model u_host (.clk_sys(clk_sys), .dq_out(dq_out), .dq_oe(dq_oe), .select_n(sel_n),
    .write_enable_n(we_n), .byte_write_enable_n(ben_n), .sync_address_in(addr), .dq_in(dq_in),
    .ec_mode_select(ecm), .sleep_request(slp), .read_protocol_select(rps), .output_enable_n(oe_n));
  late_write_sram_dual_bank_parity u_dut (.clk_sys(clk_sys), .ce(1'b1), .resetn(resetn),
    .ec_mode_select(ecm), .read_protocol_select(rps), .output_enable_n(oe_n), .sleep_request(slp),
    .select_n(sel_n), .write_enable_n(we_n), .byte_write_enable_n(ben_n), .sync_address_in(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dual_bank_parity_mode(dbm));
  ////////////////////////////////////////////////////////////////////////////////
  // compare tasks, one per result kind
  task automatic chk_w(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected word at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected flag at %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk_b
  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // buffer hit, byte write, abort and commit
  task automatic t_buffer();
    u_host.wr(A, 4'h0, W1);
    u_host.rd(A, q, oe, oe2);
    chk_w(q, W1);
    chk_b(oe, 1'b1);
    chk_b(oe2, 1'b0);
    u_host.wr(A, 4'h5, W2);
    u_host.rd(A, q, oe, oe2);
    chk_w(q, (W2 & MSK) | (W1 & ~MSK));
    u_host.wr(A, 4'hF, 36'h0);
    u_host.wr(C, 4'h0, 36'h0);
    u_host.rd(A, q, oe, oe2);
    chk_w(q, (W2 & MSK) | (W1 & ~MSK));
  endtask : t_buffer
  // full array halves, then per-lane bank choice in dual-bank mode
  task automatic t_banks();
    u_host.wr(A | TOP, 4'h0, S);
    u_host.wr(A, 4'h0, P);
    u_host.wr(C, 4'h0, 36'h0);
    u_host.rd(A | TOP, q, oe, oe2);
    chk_w(q, S);
    u_host.rd(A, q, oe, oe2);
    chk_w(q, P);
    u_host.strap(1'b0);
    chk_b(dbm, 1'b1);
    u_host.rd(A | TOP, q, oe, oe2);
    chk_w(q, {9'h001, 9'h0F0, 9'h007, 9'h0F0});
  endtask : t_banks
  // dual-bank write lands in both halves, buffer skips the check
  task automatic t_dual_write();
    u_host.wr(D | TOP, 4'h0, E);
    u_host.rd(D, q, oe, oe2);
    chk_w(q, E);
    u_host.wr(C, 4'h0, 36'h0);
    u_host.strap(1'b1);
    chk_b(dbm, 1'b0);
    u_host.rd(D | TOP, q, oe, oe2);
    chk_w(q, E);
    u_host.rd(D, q, oe, oe2);
    chk_w(q, E);
  endtask : t_dual_write
  // sleep cuts the drivers at once, refuses commands once synced, keeps the array
  task automatic t_sleep();
    u_host.sleep_set(1'b1);
    #1;
    chk_b(dq_oe, 1'b0);
    // this read still gets in during the sync lag, so only the pin gate keeps it off
    u_host.rd(A, q, oe, oe2);
    chk_b(oe, 1'b0);
    // a write while asleep must not reach buffer or array
    u_host.wr(A, 4'h0, W1);
    u_host.sleep_set(1'b0);
    u_host.idle(4);
    // full mode again; A last held the word committed in t_banks
    u_host.rd(A, q, oe, oe2);
    chk_w(q, P);
    chk_b(oe, 1'b1);
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  // reset, then the scenarios in order
  initial begin
    resetn = 1'b0;
    repeat (20) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    u_host.idle(6);
    t_buffer();
    t_banks();
    t_dual_write();
    t_sleep();
    final_report();
  end
endmodule : testbench
`default_nettype wire
